// ### bench/pbs_host.sv
`timescale 1ns/100ps
`default_nettype none
// Host controller model; moves its lines just after falling edges
module pbs_host
(
    // Clock
    input wire logic mclk,
    // Controls
    output var logic [7:0] address = 8'h00,
    output var logic chip_select_one_n = 1'b1,
    output var logic chip_select_two = 1'b0,
    output var logic chip_select_three_n = 1'b1,
    output var logic advance_or_load_n = 1'b0,
    output var logic writeSelect_n = 1'b1,
    output var logic [3:0] byte_lane_write_n = 4'hf,
    output var logic clock_gate_n = 1'b0,
    output var logic burstOrder = 1'b0,
    output var logic outputDrive_n = 1'b0,
    output var logic sleep_request = 1'b0,
    // Write data
    output var logic [31:0] dataIn = 32'h0,
    output var logic [3:0] parityIn = 4'h0
);
    // One slot; ctl is {drive_n, order, select, advance, write_n, stall}
    task automatic slot(input logic [5:0] ctl, input logic [3:0] ln,
        input logic [7:0] a, input logic dv, input logic [35:0] wd);
        @(negedge mclk);
        {outputDrive_n, burstOrder, chip_select_two} <= ctl[5:3];
        chip_select_one_n <= !ctl[3];
        chip_select_three_n <= !ctl[3];
        {advance_or_load_n, writeSelect_n, clock_gate_n} <= ctl[2:0];
        byte_lane_write_n <= ln;
        address <= a;
        // Idle data lines toggle so a stale word never looks valid
        {parityIn, dataIn} <= dv ? wd : ~{parityIn, dataIn};
    endtask

    // Sleep entry after a drained deselect, exit with selects held idle
    task automatic doze(input logic z);
        if (z)
        begin
            repeat (2) slot(6'h00, 4'hf, 8'h00, 1'b0, 36'h0);
            @(negedge mclk);
            sleep_request <= 1'b1;
            repeat (3) @(negedge mclk);
        end
        else
        begin
            @(negedge mclk);
            sleep_request <= 1'b0;
            repeat (3) slot(6'h00, 4'hf, 8'h00, 1'b0, 36'h0);
        end
    endtask
endmodule
`default_nettype wire

// ### bench/pbs_sram_port_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// Pin-level checks of the port
module pbs_sram_port_asserts
(
    // Clock and reset
    input wire mclk,
    input wire arst_n,
    // Controls
    input wire chip_select_one_n,
    input wire chip_select_two,
    input wire chip_select_three_n,
    input wire advance_or_load_n,
    input wire writeSelect_n,
    input wire [3:0] byte_lane_write_n,
    input wire clock_gate_n,
    input wire outputDrive_n,
    input wire sleep_request,
    // Outputs
    input wire [31:0] dataOut_r,
    input wire dataOe_n_r,
    input wire sleeping_r
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // Decoded operations on edges that are neither stalled nor asleep
    wire go = !clock_gate_n && !sleep_request && !sleeping_r;
    wire sel = !chip_select_one_n && chip_select_two && !chip_select_three_n;
    wire ld = go && !advance_or_load_n;
    wire rd = ld && sel && writeSelect_n && !outputDrive_n;
    wire wr = ld && sel && !writeSelect_n && byte_lane_write_n != 4'hf;
    sequence sLive; go && !outputDrive_n; endsequence
    sequence sWrite; wr ##1 go; endsequence
    sequence sIdle; ld && !sel ##1 go; endsequence

    a_read_drive: assert property (rd ##1 sLive |=> !dataOe_n_r)
        else $error("read beat not driven");
    a_burst_drive: assert property (rd ##1 advance_or_load_n ##0 sLive ##1 sLive |=> !dataOe_n_r)
        else $error("second read beat not driven");
    a_write_float: assert property (sWrite |=> dataOe_n_r)
        else $error("lines driven in write");
    a_deselect_float: assert property (sIdle |=> dataOe_n_r)
        else $error("lines driven after deselect");
    a_dummy_float: assert property (outputDrive_n && go |=> dataOe_n_r)
        else $error("lines driven without output drive");
    a_stall_hold: assert property (clock_gate_n && !sleep_request && !sleeping_r
        |=> $stable(dataOut_r) && $stable(dataOe_n_r))
        else $error("outputs moved on stalled edge");
    a_sleep_float: assert property (sleep_request ##1 sleep_request |-> dataOe_n_r)
        else $error("lines driven in sleep");
    a_sleep_entry: assert property (sleep_request [*3] |-> sleeping_r)
        else $error("sleep entry late");
    a_sleep_exit: assert property (!sleep_request [*4] |-> !sleeping_r)
        else $error("sleep exit late");
    a_asleep_float: assert property (sleeping_r |-> dataOe_n_r)
        else $error("lines driven while asleep");
endmodule
bind pbs_sram_port pbs_sram_port_asserts pbs_sram_port_asserts_inst (.mclk, .arst_n,
    .chip_select_one_n, .chip_select_two, .chip_select_three_n, .advance_or_load_n,
    .writeSelect_n, .byte_lane_write_n, .clock_gate_n, .outputDrive_n, .sleep_request,
    .dataOut_r, .dataOe_n_r, .sleeping_r);
`default_nettype wire

// ### bench/tb_pipelined_burst_sram_port.sv
`timescale 1ns/100ps
`default_nettype none
// Host model drives; a watcher scores read beats against a shadow memory
module tb_pipelined_burst_sram_port;
    localparam int LimitCycles = 3000;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic gateTaken = 1'b0;
    logic [31:0] lfsr = 32'hbf5487e2;
    logic [35:0] mem [256];
    logic [35:0] expq [$];
    int err_total = 0;
    int samples_checked = 0;
    wire [7:0] address;
    wire [3:0] byte_lane_write_n, parityIn, parity_lines_r;
    wire [31:0] dataIn, dataOut_r;
    wire chip_select_one_n, chip_select_two, chip_select_three_n, advance_or_load_n;
    wire writeSelect_n, clock_gate_n, burstOrder, outputDrive_n, sleep_request;
    wire dataOe_n_r, sleeping_r;

    pbs_host host (.mclk, .address, .chip_select_one_n, .chip_select_two,
        .chip_select_three_n, .advance_or_load_n, .writeSelect_n, .byte_lane_write_n,
        .clock_gate_n, .burstOrder, .outputDrive_n, .sleep_request, .dataIn, .parityIn);
    pbs_sram_port pbs_sram_port_inst (.mclk, .arst_n, .address, .chip_select_one_n,
        .chip_select_two, .chip_select_three_n, .advance_or_load_n, .writeSelect_n,
        .byte_lane_write_n, .clock_gate_n, .burstOrder, .outputDrive_n, .sleep_request,
        .dataIn, .parityIn, .dataOut_r, .parity_lines_r, .dataOe_n_r, .sleeping_r);

    // 10 MHz clock
    initial
    begin
        forever #50 mclk = ~mclk;
    end

    function automatic logic [31:0] step(input logic [31:0] r);
        step = {r[30:0], 1'b0} ^ (r[31] ? 32'h04c11db7 : 32'h0);
    endfunction

    function automatic logic [7:0] beatAddr(input logic [7:0] a, input int k, input logic o);
        beatAddr = {a[7:2], o ? (a[1:0] ^ 2'(k)) : (a[1:0] + 2'(k))};
    endfunction

    task automatic check(input logic [35:0] exp, input logic [35:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: expected %h got %h", $time, exp, got);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Write burst; beat sk has no lanes; data trails its beat by two slots
    task automatic wrBurst(input logic [7:0] a, input int n, input logic o, input logic full,
        input int sk);
        logic [35:0] wd [6];
        logic [3:0] ln;
        logic [7:0] ba;
        logic live;
        live = 1'b1;
        for (int k = 0; k < n + 2; k++)
        begin
            lfsr = step(lfsr);
            wd[k] = {lfsr[3:0], lfsr};
            ln = (k == sk) ? 4'hf : (full ? 4'h0 : lfsr[11:8]);
            if (k == 0)
                live = (ln != 4'hf);
            ba = beatAddr(a, k, o);
            for (int g = 0; g < 4; g++)
                if (live && k < n && !ln[g])
                begin
                    mem[ba][8 * g +: 8] = wd[k][8 * g +: 8];
                    mem[ba][32 + g] = wd[k][32 + g];
                end
            host.slot(k < n ? {1'b0, o, k == 0, k != 0, k != 0 && lfsr[20], 1'b0} : 6'h00, ln,
                k == 0 ? a : lfsr[31:24], k > 1, k > 1 ? wd[k - 2] : 36'h0);
        end
    endtask

    // Read burst; a stall slot with junk controls precedes beat st
    task automatic rdBurst(input logic [7:0] a, input int n, input logic o, input logic dum,
        input int st);
        for (int k = 0; k < n; k++)
        begin
            lfsr = step(lfsr);
            if (k == st)
                host.slot({1'b0, o, lfsr[2:0], 1'b1}, lfsr[7:4], lfsr[15:8], 1'b0, 36'h0);
            if (!dum)
                expq.push_back(mem[beatAddr(a, k, o)]);
            host.slot({dum, o, k == 0, k != 0, k == 0 || lfsr[20], 1'b0}, lfsr[7:4],
                k == 0 ? a : lfsr[31:24], 1'b0, 36'h0);
        end
        repeat (2) host.slot({dum, 5'h00}, 4'hf, 8'h00, 1'b0, 36'h0);
    endtask

    // Every unstalled edge that leaves the lines driven delivers one beat
    always @(posedge mclk)
        gateTaken <= !clock_gate_n && arst_n;
    always @(negedge mclk)
        if (gateTaken && dataOe_n_r !== 1'b1)
            check(expq.size() > 0 ? expq.pop_front() : 36'hx, {parity_lines_r, dataOut_r});

    // Main sequence
    initial
    begin
        logic [7:0] a;
        repeat (2) @(negedge mclk);
        arst_n <= 1'b1;
        for (int o = 0; o < 2; o++)
            for (int s = 0; s < 4; s++)
            begin
                a = {3'h1, o[0], 2'(s), 2'(s)};
                wrBurst(a, 4, o[0], 1'b1, 9);
                wrBurst(a, 4, !o[0], 1'b0, s);
                rdBurst(a, 4, o[0], 1'b0, s);
                $display("test burst order %0d start %0d done", o, s);
            end
        rdBurst(8'h24, 2, 1'b1, 1'b1, 9);
        $display("test dummy read done");
        host.doze(1'b1);
        check(36'h1, {35'h0, sleeping_r});
        host.doze(1'b0);
        check(36'h0, {35'h0, sleeping_r});
        rdBurst(8'h2c, 4, 1'b0, 1'b0, 9);
        repeat (3) @(negedge mclk);
        check(36'h0, 36'(expq.size()));
        $display("test sleep done");
        results();
    end

    // Watchdog well beyond the expected run length
    initial
    begin
        repeat (LimitCycles) @(posedge mclk);
        err_total++;
        results();
    end
endmodule
`default_nettype wire

// ### hdl/pbs_burst_counter.v
`timescale 1ns/100ps
`default_nettype none
`include "pbs_consts.vh"
// Low two address bits of the burst, linear or interleaved
module pbs_burst_counter
(
    // Clock and reset
    input wire mclk,
    input wire arst_n,
    // Control
    input wire load,
    input wire advance,
    input wire [1:0] startBits,
    input wire burstOrder,
    // Result
    output wire [1:0] lowBits
);
    reg [1:0] startBits_r;
    reg [1:0] beat_r;
    reg [1:0] lowBits_nxt;
    reg [1:0] beat_nxt;

    // Start bits and beat number kept; address derived from both
    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            startBits_r <= 2'h0;
            beat_r <= 2'h0;
        end
        else if (load)
        begin
            startBits_r <= startBits;
            beat_r <= 2'h0;
        end
        else if (advance)
            beat_r <= beat_nxt; // Wraps after four beats
    end

    // Interleave xors the beat, linear adds it
    // Uses the following beat, so an advancing edge repeats the start only when the beat wraps, on the fourth advance
    always @*
    begin
        beat_nxt = beat_r + `PBS_BURST_STEP;
        if (burstOrder == `PBS_ORDER_LINEAR)
            lowBits_nxt = startBits_r + beat_nxt;
        else
            lowBits_nxt = startBits_r ^ beat_nxt;
    end

    assign lowBits = lowBits_nxt;
endmodule
`default_nettype wire

// ### hdl/pbs_consts.vh
`ifndef PBS_CONSTS_VH
`define PBS_CONSTS_VH
// Port geometry
`define PBS_ADDR_W 8
`define PBS_LANES 4
`define PBS_LANE_W 9
`define PBS_DATA_W 32
`define PBS_PAR_W 4
`define PBS_WORD_W 36
`define PBS_DEPTH 256
// Burst order
`define PBS_ORDER_LINEAR 1'b0
`define PBS_ORDER_INTERLEAVED 1'b1
// Interleave offsets for beats two to four
`define PBS_XOR_BEAT1 2'h1
`define PBS_XOR_BEAT2 2'h2
`define PBS_XOR_BEAT3 2'h3
`define PBS_BURST_STEP 2'h1
// Sleep timing
`define PBS_CLK_PERIOD_NS 100
`define PBS_CYCLE_PERIOD_COUNT 2
`define PBS_SLEEP_ENTRY_NS (`PBS_CYCLE_PERIOD_COUNT * `PBS_CLK_PERIOD_NS)
`define PBS_SLEEP_RECOVERY_NS (`PBS_CYCLE_PERIOD_COUNT * `PBS_CLK_PERIOD_NS)
`define PBS_SLEEP_ENTRY_CYC ((`PBS_SLEEP_ENTRY_NS + `PBS_CLK_PERIOD_NS - 1) / `PBS_CLK_PERIOD_NS)
`define PBS_SLEEP_REC_CYC ((`PBS_SLEEP_RECOVERY_NS + `PBS_CLK_PERIOD_NS - 1) / `PBS_CLK_PERIOD_NS)
`define PBS_SLEEP_CNT_W 2
`endif

// ### hdl/pbs_sleep_ctrl.v
`timescale 1ns/100ps
`default_nettype none
`include "pbs_consts.vh"
// Sleep entry and exit sequencing
module pbs_sleep_ctrl
(
    // Clock and reset
    input wire mclk,
    input wire arst_n,
    // Request
    input wire sleepRequest,
    // Status
    output wire asleep,
    output wire sleepBusy
);
    localparam [2:0] ST_AWAKE = 3'h1;
    localparam [2:0] ST_ENTER = 3'h2;
    localparam [2:0] ST_SLEEP = 3'h4;
    // Entry counts its first edge in the awake state; exit counts both
    localparam integer ENTRY_LEFT = `PBS_SLEEP_ENTRY_CYC - 2;
    localparam integer REC_LEFT = `PBS_SLEEP_REC_CYC - 1;
    localparam [`PBS_SLEEP_CNT_W-1:0] ENTRY_LOAD = ENTRY_LEFT[`PBS_SLEEP_CNT_W-1:0];
    localparam [`PBS_SLEEP_CNT_W-1:0] REC_LOAD = REC_LEFT[`PBS_SLEEP_CNT_W-1:0];

    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [`PBS_SLEEP_CNT_W-1:0] cnt_r;
    reg [`PBS_SLEEP_CNT_W-1:0] cnt_nxt;

    // Next state; exit leaves ST_SLEEP only after recovery count
    always @*
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            ST_AWAKE:
            begin
                if (sleepRequest)
                begin
                    state_nxt = ST_ENTER;
                    cnt_nxt = ENTRY_LOAD;
                end
            end
            ST_ENTER:
            begin
                if (!sleepRequest)
                    state_nxt = ST_AWAKE;
                else if (cnt_r == {`PBS_SLEEP_CNT_W{1'b0}})
                begin
                    state_nxt = ST_SLEEP;
                    cnt_nxt = REC_LOAD;
                end
                else
                    cnt_nxt = cnt_r - 1'b1;
            end
            ST_SLEEP:
            begin
                if (sleepRequest)
                    cnt_nxt = REC_LOAD;
                else if (cnt_r == {`PBS_SLEEP_CNT_W{1'b0}})
                    state_nxt = ST_AWAKE;
                else
                    cnt_nxt = cnt_r - 1'b1;
            end
            default:
            begin
                state_nxt = ST_AWAKE;
                cnt_nxt = {`PBS_SLEEP_CNT_W{1'b0}};
            end
        endcase
    end

    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= ST_AWAKE;
            cnt_r <= {`PBS_SLEEP_CNT_W{1'b0}};
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Looks one state ahead so a registered copy lines up with the state
    assign asleep = (state_nxt == ST_SLEEP);
    assign sleepBusy = (state_r != ST_AWAKE);
endmodule
`default_nettype wire

// ### hdl/pbs_sram_port.v
// Notes on behaviour
// - One address serves up to four write beats
// - Advance high ignores selects, steps counter
// - Sleep request async; tristate, ignore inputs
// - Sleep entry and exit take two cycles
// - Access pending at sleep entry is dropped
// - Order high: interleaved xor sequence
// - Order low: linear count with wrap
// - Selected load, write high: read burst
// - Read without output drive: dummy read
// - Selected load, write low, lane: write
// - Write start with no lanes aborts
// - Beat with no lanes skips, still advances
// - Clock gate high freezes all but sleep state and stage-two read drive enable
// - Write cycle tristates all data lines
// - Power-up deselected, data lines tristated
// - Output drive unsampled, masked on writes
// - Each lane gates its byte and parity
// - Read data one cycle after load
// - Deselect tristates after the next rise
`timescale 1ns/100ps
`default_nettype none
`include "pbs_consts.vh"
module pbs_sram_port
(
    // Clock and reset
    input wire mclk,
    input wire arst_n,
    // Address and control
    input wire [`PBS_ADDR_W-1:0] address,
    input wire chip_select_one_n,
    input wire chip_select_two,
    input wire chip_select_three_n,
    input wire advance_or_load_n,
    input wire writeSelect_n,
    input wire [`PBS_LANES-1:0] byte_lane_write_n,
    input wire clock_gate_n,
    input wire burstOrder,
    input wire outputDrive_n,
    input wire sleep_request,
    // Data lines
    input wire [`PBS_DATA_W-1:0] dataIn,
    input wire [`PBS_PAR_W-1:0] parityIn,
    output reg [`PBS_DATA_W-1:0] dataOut_r,
    output reg [`PBS_PAR_W-1:0] parity_lines_r,
    output reg dataOe_n_r,
    // Status
    output reg sleeping_r
);

    // Stage one: access taken this rise
    reg s1Valid_r;
    reg s1Write_r;
    reg [`PBS_ADDR_W-1:0] s1Addr_r;
    reg [`PBS_LANES-1:0] s1Lanes_n_r;
    // Stage two: write beat waiting for data, or read driving
    reg s2Write_r;
    reg s2Read_r;
    reg [`PBS_ADDR_W-1:0] s2Addr_r;
    reg [`PBS_LANES-1:0] s2Lanes_n_r;
    // Burst context
    reg burstActive_r;
    reg burstWrite_r;
    reg [`PBS_ADDR_W-3:0] burstHigh_r;

    wire asleep;
    wire sleepBusy;
    wire [1:0] lowBits;
    wire [`PBS_WORD_W-1:0] rdWord;

    // Chip selects all active
    function selected;
        input cs1n;
        input cs2;
        input cs3n;
        begin
            selected = !cs1n && cs2 && !cs3n;
        end
    endfunction

    // Sleep request bypasses the gate and freezes the port
    wire halted = sleep_request || sleepBusy;
    wire tick = !clock_gate_n && !halted;
    wire isSel = selected(chip_select_one_n, chip_select_two, chip_select_three_n);
    wire doLoad = tick && !advance_or_load_n;
    wire doAdvance = tick && advance_or_load_n && burstActive_r;
    wire loadRead = doLoad && isSel && writeSelect_n;
    wire loadWrite = doLoad && isSel && !writeSelect_n && !(&byte_lane_write_n);

    pbs_burst_counter u_counter
    (
        .mclk(mclk),
        .arst_n(arst_n),
        .load(loadRead || loadWrite),
        .advance(doAdvance),
        .startBits(address[1:0]),
        .burstOrder(burstOrder),
        .lowBits(lowBits)
    );

    pbs_sleep_ctrl u_sleep
    (
        .mclk(mclk),
        .arst_n(arst_n),
        .sleepRequest(sleep_request),
        .asleep(asleep),
        .sleepBusy(sleepBusy)
    );

    // Address of the beat that the next advance takes
    wire [`PBS_ADDR_W-1:0] beatAddr = {burstHigh_r, lowBits};

    // Burst context; write abort start carries no address
    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            burstActive_r <= 1'b0;
            burstWrite_r <= 1'b0;
            burstHigh_r <= {(`PBS_ADDR_W-2){1'b0}};
        end
        else if (halted)
            burstActive_r <= 1'b0;
        else if (doLoad)
        begin
            burstActive_r <= loadRead || loadWrite;
            burstWrite_r <= loadWrite;
            if (loadRead || loadWrite)
                burstHigh_r <= address[`PBS_ADDR_W-1:2];
        end
    end

    // Stage one captures the beat of this rise
    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s1Valid_r <= 1'b0;
            s1Write_r <= 1'b0;
            s1Addr_r <= {`PBS_ADDR_W{1'b0}};
            s1Lanes_n_r <= {`PBS_LANES{1'b1}};
        end
        else if (halted)
            s1Valid_r <= 1'b0;
        else if (tick)
        begin
            s1Lanes_n_r <= byte_lane_write_n;
            if (loadRead || loadWrite)
            begin
                s1Valid_r <= 1'b1;
                s1Write_r <= loadWrite;
                s1Addr_r <= address;
            end
            else if (doAdvance)
            begin
                s1Valid_r <= 1'b1;
                s1Write_r <= burstWrite_r;
                s1Addr_r <= beatAddr;
            end
            else
                s1Valid_r <= 1'b0;
        end
    end

    // Stage two: reads present data, writes await data
    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s2Write_r <= 1'b0;
            s2Read_r <= 1'b0;
            s2Addr_r <= {`PBS_ADDR_W{1'b0}};
            s2Lanes_n_r <= {`PBS_LANES{1'b1}};
        end
        else if (halted)
        begin
            s2Write_r <= 1'b0;
            s2Read_r <= 1'b0;
        end
        else if (tick)
        begin
            s2Write_r <= s1Valid_r && s1Write_r;
            s2Read_r <= s1Valid_r && !s1Write_r;
            s2Addr_r <= s1Addr_r;
            s2Lanes_n_r <= s1Lanes_n_r;
        end
    end

    // Lane writes on the second rise after load; memory kept asleep
    // One array per lane, so every lane's store has a single writer
    genvar g;
    generate
        for (g = 0; g < `PBS_LANES; g = g + 1)
        begin : gLane
            reg [`PBS_LANE_W-1:0] laneMem [0:`PBS_DEPTH-1];
            always @(posedge mclk)
            begin
                if (tick && s2Write_r && !s2Lanes_n_r[g])
                    laneMem[s2Addr_r] <= {parityIn[g], dataIn[g*8 +: 8]};
            end
            // Data bytes low, parity bits above them, as on the pins
            assign rdWord[g*8 +: 8] = laneMem[s1Addr_r][7:0];
            assign rdWord[`PBS_DATA_W + g] = laneMem[s1Addr_r][8];
        end
    endgenerate

    // Output register; drive only for selected reads with drive on
    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dataOut_r <= {`PBS_DATA_W{1'b0}};
            parity_lines_r <= {`PBS_PAR_W{1'b0}};
            dataOe_n_r <= 1'b1;
            sleeping_r <= 1'b0;
        end
        else
        begin
            sleeping_r <= asleep;
            if (halted)
                dataOe_n_r <= 1'b1;
            else if (tick)
            begin
                if (s1Valid_r && !s1Write_r)
                begin
                    dataOut_r <= rdWord[`PBS_DATA_W-1:0];
                    parity_lines_r <= rdWord[`PBS_WORD_W-1:`PBS_DATA_W];
                end
                // Dummy reads and writes leave the lines floating
                dataOe_n_r <= !(s1Valid_r && !s1Write_r) || outputDrive_n;
            end
            else if (s2Read_r)
                dataOe_n_r <= outputDrive_n;
        end
    end
endmodule
`default_nettype wire
